// [core/rvam_pkg.sv]
package rvam_pkg;
   typedef struct packed {
      logic        valid;
      logic [11:0] addr;
   } rvam_fetch_t;
endpackage

// [core/rvam_regs.svh]
`ifndef RVAM_REGS_SVH
`define RVAM_REGS_SVH
// ==========================================================
// vector map
`define RVAM_ADDR_W          12
`define RVAM_SRC_N           31
`define RVAM_RESET_VEC       12'h000
`define RVAM_VEC_BASE        12'h001
`define RVAM_VEC_RESERVED_0  12'h00E
`define RVAM_VEC_RESERVED_1  12'h01D
`define RVAM_VEC_RESERVED_2  12'h01E
`define RVAM_VEC_LAST        12'h01F
`define RVAM_FUSE_PROGRAMMED 1'h0
`define RVAM_BOOT_ADDR_DEF   12'hC00
`endif

// [core/rvam_vector_map.sv]
`timescale 1ns/1ps
`include "rvam_regs.svh"
module rvam_vector_map #(
   parameter logic [11:0] BOOT_ADDR = `RVAM_BOOT_ADDR_DEF
) (
   input  wire logic                 I_SYS_CLK,
   input  wire logic                 I_RST_N,
   input  wire logic                 i_boot_reset_fuse,
   input  wire logic                 i_vector_relocate_bit,
   input  wire logic [30:0]          i_irq,
   input  wire logic                 i_ack,
   output rvam_pkg::rvam_fetch_t     o_fetch,
   output logic                      o_reset_fetch,
   output logic [11:0]               o_reset_addr
);
   // a zero boot base would make relocation indistinguishable from the plain table
   if (BOOT_ADDR == 12'h000) begin : g_bad_boot
      $error("boot address must be nonzero");
   end

   // ==========================================================
   // source index to table address
   // bit k of i_irq is table entry k+1; entries 0E,1D,1E have no source
   function automatic logic [11:0] table_addr(input logic [4:0] idx);
      table_addr = 12'(idx) + `RVAM_VEC_BASE;
   endfunction

   function automatic logic is_hole(input logic [4:0] idx);
      logic [11:0] a;
      a = table_addr(idx);
      is_hole = (a == `RVAM_VEC_RESERVED_0) || (a == `RVAM_VEC_RESERVED_1) ||
                (a == `RVAM_VEC_RESERVED_2);
   endfunction

   // ==========================================================
   // pin synchronisers
   logic [1:0]  fuse_sync;
   logic [1:0]  sel_sync;
   logic [30:0] irq_s1;
   logic [30:0] irq_s2;

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         fuse_sync <= 2'h3;
         sel_sync  <= 2'h0;
      end else begin
         fuse_sync <= {fuse_sync[0], i_boot_reset_fuse};
         sel_sync  <= {sel_sync[0], i_vector_relocate_bit};
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         irq_s1 <= 31'h0;
         irq_s2 <= 31'h0;
      end else begin
         irq_s1 <= i_irq;
         irq_s2 <= irq_s1;
      end
   end

   // ==========================================================
   // reset vector: fetch pulse after release, address from fuse
   logic       booting;
   logic [1:0] boot_cnt;
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         booting  <= 1'h1;
         boot_cnt <= 2'h0;
      end else if (booting) begin
         boot_cnt <= boot_cnt + 2'h1;
         // wait for synchronised fuse before issuing the reset fetch
         if (boot_cnt == 2'h2) begin
            booting <= 1'h0;
         end
      end
   end

   logic [11:0] next_reset_addr;
   always_comb begin
      next_reset_addr = (fuse_sync[1] == `RVAM_FUSE_PROGRAMMED) ? BOOT_ADDR
                                                               : `RVAM_RESET_VEC;
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         o_reset_addr  <= `RVAM_RESET_VEC;
         o_reset_fetch <= 1'h0;
      end else begin
         o_reset_addr  <= next_reset_addr;
         o_reset_fetch <= booting && (boot_cnt == 2'h2);
      end
   end

   // ==========================================================
   // priority pick: lowest source index wins
   logic        hit;
   logic [4:0]  pick;
   always_comb begin
      hit  = 1'h0;
      pick = 5'h0;
      for (int k = `RVAM_SRC_N - 1; k >= 0; k--) begin
         if (irq_s2[k] && !is_hole(5'(k))) begin
            hit  = 1'h1;
            pick = 5'(k);
         end
      end
   end

   logic [11:0] next_vec;
   always_comb begin
      next_vec = table_addr(pick);
      if (sel_sync[1]) begin
         next_vec = table_addr(pick) + BOOT_ADDR;
      end
   end

   // ==========================================================
   // vector output holds until the core acknowledges
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         o_fetch <= '0;
      end else if (booting) begin
         o_fetch <= '0;
      end else if (!o_fetch.valid || i_ack) begin
         o_fetch.valid <= hit && !(o_fetch.valid && i_ack);
         o_fetch.addr  <= next_vec;
      end
   end

   // ==========================================================
   // checks
   p_reset_app: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      o_reset_fetch && $past(fuse_sync[1]) |-> o_reset_addr == 12'h000)
      else $error("reset address not zero with fuse unprogrammed");
   p_reset_boot: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      o_reset_fetch && !$past(fuse_sync[1]) |-> o_reset_addr == BOOT_ADDR)
      else $error("reset address not boot address with fuse programmed");
   property p_reset_once;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N) o_reset_fetch |=> !o_reset_fetch[*8];
   endproperty
   a_reset_once: assert property (p_reset_once) else $error("reset fetch repeated");
   property p_vec_range;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
         o_fetch.valid && !sel_sync[1] && $stable(sel_sync[1]) && $past(o_fetch.valid) == 1'h0
         |-> o_fetch.addr >= 12'h001 && o_fetch.addr <= 12'h01F;
   endproperty
   a_vec_range: assert property (p_vec_range) else $error("vector outside table");
   property p_no_hole;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
         o_fetch.valid && !sel_sync[1] && $past(!sel_sync[1])
         |-> o_fetch.addr != 12'h00E && o_fetch.addr != 12'h01D && o_fetch.addr != 12'h01E;
   endproperty
   a_no_hole: assert property (p_no_hole) else $error("vector to empty slot");
   property p_relocated;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
         o_fetch.valid && sel_sync[1] && $past(sel_sync[1]) && $past(sel_sync[1], 2)
         && $changed(o_fetch.addr) |-> o_fetch.addr > BOOT_ADDR;
   endproperty
   a_relocated: assert property (p_relocated) else $error("vector not relocated");
   property p_lowest;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
         !booting && !o_fetch.valid && irq_s2[0] |=> o_fetch.valid &&
         o_fetch.addr[4:0] == 5'h01;
   endproperty
   a_lowest: assert property (p_lowest) else $error("lowest request not chosen");
   property p_hold;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
         o_fetch.valid && !i_ack |=> o_fetch.valid && $stable(o_fetch.addr);
   endproperty
   a_hold: assert property (p_hold) else $error("vector dropped before ack");
   property p_idle;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N) booting |=> !o_fetch.valid;
   endproperty
   a_idle: assert property (p_idle) else $error("vector during reset");
   property p_last;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
         !booting && !o_fetch.valid && !sel_sync[1] && irq_s2 == 31'h40000000
         |=> o_fetch.valid && o_fetch.addr == 12'h01F;
   endproperty
   a_last: assert property (p_last) else $error("store ready vector wrong");

   c_boot: cover property (@(posedge I_SYS_CLK) o_reset_fetch && o_reset_addr == BOOT_ADDR);
   c_app: cover property (@(posedge I_SYS_CLK) o_reset_fetch && o_reset_addr == 12'h000);
   c_reloc: cover property (@(posedge I_SYS_CLK) o_fetch.valid && sel_sync[1]);
   c_ack: cover property (@(posedge I_SYS_CLK) o_fetch.valid && i_ack);
endmodule

// [testbench/rvam_core_model.sv]
`timescale 1ns/1ps
// ==========================================
// core fetch side and interrupt sources
module rvam_core_model (
   input  wire logic                  I_SYS_CLK,
   input  wire logic                  I_RST_N,
   input  wire logic [30:0]           i_set,
   input  wire logic [3:0]            i_delay,
   input  wire rvam_pkg::rvam_fetch_t i_fetch,
   output logic      [30:0]           o_irq,
   output logic                       o_ack
);
   logic [3:0] wait_cnt;
   // a source drops its level only when its own vector is taken
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         o_irq <= '0;
      end else if (o_ack && i_fetch.valid) begin
         o_irq <= (o_irq | i_set) & ~(31'h1 << (i_fetch.addr[4:0] - 5'h01));
      end else begin
         o_irq <= o_irq | i_set;
      end
   end
   // slow answers keep the offer standing for i_delay extra cycles
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N || !i_fetch.valid || o_ack) begin
         wait_cnt <= 4'h0;
         o_ack <= 1'b0;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
         o_ack <= (wait_cnt >= i_delay);
      end
   end
endmodule

// [testbench/tb_rvam_vector_map.sv]
`timescale 1ns/1ps
`include "rvam_regs.svh"
module tb_rvam_vector_map;
   logic                  clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  fuse = 1'b1;
   logic                  reloc = 1'b0;
   logic [30:0]           set_mask = '0;
   logic [3:0]            delay = 4'h0;
   logic [30:0]           irq;
   logic                  ack;
   logic                  rst_fetch;
   logic [11:0]           rst_addr;
   rvam_pkg::rvam_fetch_t fetch;
   logic [11:0]           seen[$];
   int                    bad_count = 0;
   int                    cmp_count = 0;
   always #5 clk = ~clk;
   rvam_vector_map dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .i_boot_reset_fuse(fuse), .i_vector_relocate_bit(reloc),
      .i_irq(irq), .i_ack(ack), .o_fetch(fetch), .o_reset_fetch(rst_fetch), .o_reset_addr(rst_addr));
   rvam_core_model core (.I_SYS_CLK(clk), .I_RST_N(rst_n), .i_set(set_mask), .i_delay(delay), .i_fetch(fetch),
      .o_irq(irq), .o_ack(ack));
   // a re-offer of the same vector right after its ack is the sync lag, not a second request
   always @(posedge clk) begin
      if (ack === 1'b1 && fetch.valid === 1'b1 && (seen.size() == 0 || seen[$] !== fetch.addr)) begin
         seen.push_back(fetch.addr);
      end
   end
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset(input logic f, input logic r);
      int n;
      @(posedge clk);
      rst_n <= 1'b0;
      fuse <= f;
      reloc <= r;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      n = 0;
      while (rst_fetch !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      if (n == 20) begin
         bad_count++;
         wrap_up();
      end
      chk(rst_addr, f ? `RVAM_RESET_VEC : `RVAM_BOOT_ADDR_DEF);
      $display("reset test done");
   endtask
   task automatic t_each(input logic [11:0] base);
      int n;
      for (int k = 0; k < 31; k++) begin
         // let the re-offer of the previous vector drain before recording
         repeat (8) @(posedge clk);
         seen.delete();
         @(posedge clk);
         set_mask <= 31'h1 << k;
         @(posedge clk);
         set_mask <= '0;
         n = 0;
         while (seen.size() == 0 && n < 12) begin
            @(negedge clk);
            n++;
         end
         if (k == 13 || k == 28 || k == 29) chk(12'(seen.size()), 12'h000);
         else if (seen.size() == 0) begin
            bad_count++;
            wrap_up();
         end
         else chk(seen[0], base + 12'(k + 1));
      end
      $display("vector table test done");
   endtask
   task automatic t_prio();
      int n;
      int i;
      repeat (8) @(posedge clk);
      seen.delete();
      @(posedge clk);
      delay <= 4'h3;
      set_mask <= '1;
      @(posedge clk);
      set_mask <= '0;
      n = 0;
      while (seen.size() < 28 && n < 1000) begin
         @(negedge clk);
         n++;
      end
      if (n == 1000) begin
         bad_count++;
         wrap_up();
      end
      i = 0;
      for (int k = 0; k < 31; k++) begin
         if (k != 13 && k != 28 && k != 29) begin
            chk(seen[i], `RVAM_BOOT_ADDR_DEF + 12'(k + 1));
            i++;
         end
      end
      $display("priority test done");
   endtask
   initial begin
      t_reset(1'b1, 1'b0);
      t_each(`RVAM_RESET_VEC);
      t_reset(1'b0, 1'b0);
      t_reset(1'b1, 1'b1);
      t_reset(1'b0, 1'b1);
      t_each(`RVAM_BOOT_ADDR_DEF);
      t_prio();
      wrap_up();
   end
endmodule
